// >>> core/pmv_bit_sampler.sv
// Serial clock domain front end: samples the data pin on each rising bus clock.
// Assumes the host holds data stable around the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module pmv_bit_sampler (
   // Link side
   input wire logic scl,
   input wire logic rst_b,
   input wire logic sda_in,
   // Toward the system clock domain
   output logic bit_toggle,
   output logic bit_value
);

   // Toggle marks each new bit; value holds until the next bus clock
   always_ff @(posedge scl or negedge rst_b) begin
      if (!rst_b) begin
         bit_toggle <= 1'b0;
         bit_value <= 1'b0;
      end else begin
         bit_toggle <= ~bit_toggle;
         bit_value <= sda_in;
      end
   end

endmodule : pmv_bit_sampler
`default_nettype wire

// >>> core/pmv_pkg.sv
// Shared constants, types and helpers for the voltage limit command bank.
// Assumes one channel, PMBus word data in binary16 form, device on one address.
package pmv_pkg;

   // Bus address of this device; the value is arbitrary
   localparam logic [6:0] DEV_ADDR = 7'h40;

   // Command codes
   localparam logic [7:0] CMD_OPERATION = 8'h01;
   localparam logic [7:0] CMD_ALERT_MASK = 8'h1B;
   localparam logic [7:0] CMD_FORMAT = 8'h20;
   localparam logic [7:0] CMD_SETPOINT = 8'h21;
   localparam logic [7:0] CMD_CEILING = 8'h24;
   localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
   localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
   localparam logic [7:0] CMD_INPUT_OFF = 8'h36;
   localparam logic [7:0] CMD_OV_FAULT = 8'h40;
   localparam logic [7:0] CMD_OV_WARN = 8'h42;
   localparam logic [7:0] CMD_UV_WARN = 8'h43;
   localparam logic [7:0] CMD_UV_FAULT = 8'h44;
   localparam logic [7:0] CMD_INPUT_LOW = 8'h58;
   localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
   localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
   localparam logic [7:0] CMD_STATUS_VOUT = 8'h7A;
   localparam logic [7:0] CMD_STATUS_INPUT = 8'h7C;
   localparam logic [7:0] CMD_STATUS_CML = 8'h7E;
   localparam logic [7:0] CMD_DISCHARGE = 8'hE4;
   localparam logic [7:0] CMD_POWER_BAD = 8'hF3;

   // Fixed and reset values
   localparam logic [7:0] FORMAT_VALUE = 8'h60;
   localparam logic [7:0] OP_RESET = 8'h00;
   localparam logic [7:0] OP_NOMINAL = 8'h80;
   localparam logic [7:0] OP_MARGIN_HIGH = 8'hA8;
   localparam logic [7:0] OP_MARGIN_LOW = 8'h98;

   // Storage indices of the word registers
   localparam int NREG = 12;
   localparam logic [3:0] IDX_SETPOINT = 4'h0;
   localparam logic [3:0] IDX_CEILING = 4'h1;
   localparam logic [3:0] IDX_MHIGH = 4'h2;
   localparam logic [3:0] IDX_MLOW = 4'h3;
   localparam logic [3:0] IDX_OVF = 4'h4;
   localparam logic [3:0] IDX_OVW = 4'h5;
   localparam logic [3:0] IDX_UVW = 4'h6;
   localparam logic [3:0] IDX_UVF = 4'h7;
   localparam logic [3:0] IDX_DIS = 4'h8;
   localparam logic [3:0] IDX_PBD = 4'h9;
   localparam logic [3:0] IDX_VINOFF = 4'hA;
   localparam logic [3:0] IDX_VINUV = 4'hB;
   localparam logic [3:0] IDX_NONE = 4'hF;

   // Binary16 figures (volts)
   localparam logic [15:0] HF_0V4 = 16'h3666;
   localparam logic [15:0] HF_1V35 = 16'h3D66;
   localparam logic [15:0] HF_1V375 = 16'h3D80;
   localparam logic [15:0] HF_2V75 = 16'h4180;
   localparam logic [15:0] HF_5V5 = 16'h4580;
   localparam logic [15:0] HF_6V0 = 16'h4600;
   localparam logic [15:0] HF_16V0 = 16'h4C00;
   localparam logic [15:0] HF_22V0 = 16'h4D80;
   localparam logic [15:0] HF_NEG1V0 = 16'hBC00;

   // Status and configuration bit positions
   localparam int SB_NONE = 0;
   localparam int SB_CML = 1;
   localparam int SW_INPUT = 13;
   localparam int SW_VOUT = 15;
   localparam int SV_MAX_WARN = 3;
   localparam int SI_VIN_UV = 5;
   localparam int SC_INVALID = 6;
   localparam int GC_NO_STRAP = 6;
   localparam int CC_RANGE_LO = 1;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;

   typedef enum {ST_IDLE, ST_ADDR, ST_CMD, ST_WRITE, ST_READ, ST_IGNORE} pmv_state_t;

   // Signed-magnitude less-than for binary16; +0 and -0 compare equal
   function automatic logic pmv_hf_lt(input logic [15:0] a, input logic [15:0] b);
      logic zeros;
      zeros = (a[14:0] == 15'h0000) && (b[14:0] == 15'h0000);
      if (a[15] != b[15]) return a[15] && !zeros;
      else if (!a[15]) return a[14:0] < b[14:0];
      else return a[14:0] > b[14:0];
   endfunction : pmv_hf_lt

   // Command code to storage index
   function automatic logic [3:0] pmv_index(input logic [7:0] c);
      case (c)
         CMD_SETPOINT: return IDX_SETPOINT;
         CMD_CEILING: return IDX_CEILING;
         CMD_MARGIN_HIGH: return IDX_MHIGH;
         CMD_MARGIN_LOW: return IDX_MLOW;
         CMD_OV_FAULT: return IDX_OVF;
         CMD_OV_WARN: return IDX_OVW;
         CMD_UV_WARN: return IDX_UVW;
         CMD_UV_FAULT: return IDX_UVF;
         CMD_DISCHARGE: return IDX_DIS;
         CMD_POWER_BAD: return IDX_PBD;
         CMD_INPUT_OFF: return IDX_VINOFF;
         CMD_INPUT_LOW: return IDX_VINUV;
         default: return IDX_NONE;
      endcase
   endfunction : pmv_index

   // Reset value of each word register
   function automatic logic [15:0] pmv_default(input logic [3:0] i);
      case (i)
         IDX_SETPOINT: return 16'h3800;
         IDX_CEILING: return 16'h384C;
         IDX_MHIGH: return 16'h3833;
         IDX_MLOW: return 16'h379A;
         IDX_OVF: return 16'h3866;
         IDX_OVW: return 16'h384C;
         IDX_UVW: return 16'h3779;
         IDX_UVF: return 16'h3771;
         IDX_DIS: return 16'h3266;
         IDX_PBD: return 16'h2E66;
         IDX_VINOFF: return HF_1V35;
         IDX_VINUV: return HF_NEG1V0;
         default: return 16'h0000;
      endcase
   endfunction : pmv_default

endpackage : pmv_pkg

// >>> core/pmv_voltage_limits.sv
// Voltage limit command bank with a PMBus slave front end.
// Assumes a 250 MHz clk, bus clock well below it, ADC samples on clk.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Input turn-off threshold 1.35..16.0 V; conversion stops at or below it.
// - Input-low warning stays suppressed until input once exceeds the threshold.
// - Input-low warning sets status byte, word, input bits and drives alert.
// - Input-low warning threshold is binary16, span -1.0..22.0 V.
// - Input-low warning comes only from ADC samples, never from threshold writes.
// - Output format byte reads 0x60.
// - Setpoint 0x21, ceiling 0x24, margins 0x25 and 0x26, read/write words.
// - Overvoltage fault/warning 0x40/0x42, undervoltage warning/fault 0x43/0x44.
// - Discharge threshold 0xE4 and power-bad delay 0xF3, read/write words.
// - Reset loads setpoint 0.5 V and ceiling 0.537 V.
// - Operation 0x80 regulates to the setpoint clamped to the ceiling.
// - Targets clamp to ceiling; crossing writes raise the ceiling warning.
// - Ceiling accepts 0.4..5.5 V.
// - Operation 0xA8 selects margin high, 0x98 margin low, both clamped.
// - Range field bits 2:1 picks 1.375, 2.75 or 5.5 V max, 0.4 V floor.
// - Overvoltage fault 0.4..6.0 V and above undervoltage and discharge levels.
// - With global bit 6 clear, populated straps replace stored values at power-up.
// - Input turn-off threshold 0x36, input-low warning 0x58, read/write words.
module pmv_voltage_limits
   import pmv_pkg::*;
(
   // System
   input wire logic clk,
   input wire logic rst_b,
   // Serial bus
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic alert_out,
   output logic alert_oe,
   // ADC input samples
   input wire logic [15:0] vin_sample,
   input wire logic vin_sample_valid,
   // Configuration
   input wire logic [7:0] global_configuration,
   input wire logic [7:0] channel_configuration,
   input wire logic res_populated,
   input wire logic [15:0] res_setpoint,
   input wire logic [15:0] res_ceiling,
   input wire logic [15:0] res_margin_high,
   input wire logic [15:0] res_margin_low,
   input wire logic [15:0] res_ov_fault,
   // Regulator controls
   output logic conversion_enable,
   output logic output_on,
   output logic [15:0] target_voltage
);

   logic [1:0] rst_sync;
   logic rst_sync_b;
   logic scl_meta, scl_s, scl_d, sda_meta, sda_s, sda_d;
   logic tgl_meta, tgl_s, tgl_d;
   logic link_toggle, link_bit;
   pmv_state_t state;
   logic [3:0] bit_idx;
   logic [7:0] shreg, cmd, low_byte, tx_byte;
   logic byte_idx, ack_pend;
   logic [15:0] regs [NREG];
   logic [7:0] operation, alert_mask;
   logic [7:0] status_vout, status_input, status_cml;
   logic strap_done, vin_armed;

   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) rst_sync <= 2'b00;
      else rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_sync_b = rst_sync[1];

   // Link domain bit capture
   pmv_bit_sampler u_sampler (
      .scl(scl),
      .rst_b(rst_b),
      .sda_in(sda_in),
      .bit_toggle(link_toggle),
      .bit_value(link_bit)
   );

   // Pins and toggle through two flops; third flop only for edges
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         {scl_meta, scl_s, scl_d} <= 3'h7;
         {sda_meta, sda_s, sda_d} <= 3'h7;
         {tgl_meta, tgl_s, tgl_d} <= 3'h0;
      end else begin
         {scl_meta, scl_s, scl_d} <= {scl, scl_meta, scl_s};
         {sda_meta, sda_s, sda_d} <= {sda_in, sda_meta, sda_s};
         {tgl_meta, tgl_s, tgl_d} <= {link_toggle, tgl_meta, tgl_s};
      end
   end

   // Bus conditions; bit value is stable for a whole bus clock
   wire start_seen = scl_s && scl_d && sda_d && !sda_s;
   wire stop_seen = scl_s && scl_d && !sda_d && sda_s;
   wire scl_fall = scl_d && !scl_s;
   wire bit_seen = tgl_s ^ tgl_d;
   wire [7:0] rx_byte = {shreg[6:0], link_bit};
   wire byte_done = bit_seen && (bit_idx == BIT_LAST);
   wire addr_hit = rx_byte[7:1] == DEV_ADDR;

   // Write decode, low byte first
   wire wr_byte_ev = byte_done && (state == ST_WRITE);
   wire wr_first = wr_byte_ev && !byte_idx;
   wire wr_word_ev = wr_byte_ev && byte_idx;
   wire [15:0] wr_data = {rx_byte, low_byte};
   wire [3:0] wr_idx = pmv_index(cmd);
   wire idx_hit = wr_idx != IDX_NONE;

   // Range and ordering checks on a written word
   wire in_vinoff = !pmv_hf_lt(wr_data, HF_1V35) && !pmv_hf_lt(HF_16V0, wr_data);
   wire in_vinuv = !pmv_hf_lt(wr_data, HF_NEG1V0) && !pmv_hf_lt(HF_22V0, wr_data);
   wire in_ceil = !pmv_hf_lt(wr_data, HF_0V4) && !pmv_hf_lt(HF_5V5, wr_data);
   wire ovf_order = pmv_hf_lt(regs[IDX_UVW], wr_data) && pmv_hf_lt(regs[IDX_UVF], wr_data)
      && pmv_hf_lt(regs[IDX_DIS], wr_data);
   wire in_ovf = !pmv_hf_lt(wr_data, HF_0V4) && !pmv_hf_lt(HF_6V0, wr_data) && ovf_order;
   wire write_ok = (wr_idx == IDX_VINOFF) ? in_vinoff :
      (wr_idx == IDX_VINUV) ? in_vinuv :
      (wr_idx == IDX_CEILING) ? in_ceil :
      (wr_idx == IDX_OVF) ? in_ovf : 1'b1;
   wire word_store = wr_word_ev && idx_hit && write_ok;
   wire invalid_ev = wr_word_ev && idx_hit && !write_ok;

   // Ceiling crossed by a target write or by a ceiling write
   wire tgt_write = (wr_idx == IDX_SETPOINT) || (wr_idx == IDX_MHIGH) || (wr_idx == IDX_MLOW);
   wire tgt_over = tgt_write && pmv_hf_lt(regs[IDX_CEILING], wr_data);
   wire ceil_under = (wr_idx == IDX_CEILING) && (pmv_hf_lt(wr_data, regs[IDX_SETPOINT])
      || pmv_hf_lt(wr_data, regs[IDX_MHIGH]) || pmv_hf_lt(wr_data, regs[IDX_MLOW]));
   wire ceil_warn_ev = word_store && (tgt_over || ceil_under);

   // Straps apply once, on the first cycle after reset release
   wire strap_load = !strap_done && res_populated && !global_configuration[GC_NO_STRAP];

   // Input monitor acts only on a fresh ADC sample
   wire vin_le_off = !pmv_hf_lt(regs[IDX_VINOFF], vin_sample);
   wire vin_above_uv = pmv_hf_lt(regs[IDX_VINUV], vin_sample);
   wire vin_warn_ev = vin_sample_valid && vin_armed && !vin_above_uv;

   // Status summaries
   wire [7:0] status_byte = {6'h00, |status_cml, |status_vout | |status_input};
   wire [15:0] status_word = {|status_vout, 1'b0, |status_input, 5'h00, status_byte};

   // Read selection; word registers come straight from storage
   wire [3:0] rd_idx = pmv_index(cmd);
   wire [15:0] rd_word = (rd_idx != IDX_NONE) ? regs[rd_idx] :
      (cmd == CMD_FORMAT) ? {8'h00, FORMAT_VALUE} :
      (cmd == CMD_OPERATION) ? {8'h00, operation} :
      (cmd == CMD_ALERT_MASK) ? {8'h00, alert_mask} :
      (cmd == CMD_STATUS_BYTE) ? {8'h00, status_byte} :
      (cmd == CMD_STATUS_WORD) ? status_word :
      (cmd == CMD_STATUS_VOUT) ? {8'h00, status_vout} :
      (cmd == CMD_STATUS_INPUT) ? {8'h00, status_input} :
      (cmd == CMD_STATUS_CML) ? {8'h00, status_cml} : 16'h0000;

   // Bus protocol; a start always resynchronises, even mid-byte
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state <= ST_IDLE;
         bit_idx <= 4'h0;
         shreg <= 8'h00;
         cmd <= 8'h00;
         low_byte <= 8'h00;
         tx_byte <= 8'h00;
         byte_idx <= 1'b0;
         ack_pend <= 1'b0;
      end else if (start_seen) begin
         state <= ST_ADDR;
         bit_idx <= 4'h0;
         ack_pend <= 1'b0;
      end else if (stop_seen) begin
         state <= ST_IDLE;
         ack_pend <= 1'b0;
      end else if (bit_seen && state != ST_IDLE) begin
         shreg <= rx_byte;
         bit_idx <= (bit_idx == BIT_ACK) ? 4'h0 : bit_idx + 4'h1;
         if (bit_idx == BIT_ACK) begin
            ack_pend <= 1'b0;
            // Host not-acknowledge ends the read; our own address acknowledge must not advance the byte
            if (state == ST_READ && !ack_pend && link_bit) state <= ST_IGNORE;
            if (state == ST_READ && !ack_pend && !link_bit) begin
               tx_byte <= byte_idx ? 8'h00 : rd_word[15:8];
               byte_idx <= 1'b1;
            end
         end
         if (byte_done) begin
            case (state)
               ST_ADDR: begin
                  ack_pend <= addr_hit;
                  state <= !addr_hit ? ST_IGNORE : rx_byte[0] ? ST_READ : ST_CMD;
                  tx_byte <= rd_word[7:0];
                  byte_idx <= 1'b0;
               end
               ST_CMD: begin
                  cmd <= rx_byte;
                  ack_pend <= 1'b1;
                  state <= ST_WRITE;
                  byte_idx <= 1'b0;
               end
               ST_WRITE: begin
                  low_byte <= rx_byte;
                  ack_pend <= 1'b1;
                  byte_idx <= 1'b1;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Data pin changes only while the bus clock is low
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) sda_oe <= 1'b0;
      else if (start_seen || stop_seen) sda_oe <= 1'b0;
      else if (scl_fall && bit_idx == BIT_ACK) sda_oe <= ack_pend;
      else if (scl_fall) sda_oe <= (state == ST_READ) && !tx_byte[~bit_idx[2:0]];
   end
   assign sda_out = 1'b0;

   // Word storage: defaults, straps, then host writes
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         for (int i = 0; i < NREG; i++) regs[i] <= pmv_default(4'(i));
      end else if (strap_load) begin
         regs[IDX_SETPOINT] <= res_setpoint;
         regs[IDX_CEILING] <= res_ceiling;
         regs[IDX_MHIGH] <= res_margin_high;
         regs[IDX_MLOW] <= res_margin_low;
         regs[IDX_OVF] <= res_ov_fault;
      end else if (word_store) begin
         regs[wr_idx] <= wr_data;
      end
   end

   // Byte controls
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         operation <= OP_RESET;
         alert_mask <= 8'h00;
         strap_done <= 1'b0;
      end else begin
         strap_done <= 1'b1;
         if (wr_first && cmd == CMD_OPERATION) operation <= rx_byte;
         if (wr_first && cmd == CMD_ALERT_MASK) alert_mask <= rx_byte;
      end
   end

   // Sticky status; a new event wins over a same-cycle clear
   wire [7:0] clr_vout = (wr_first && cmd == CMD_STATUS_VOUT) ? rx_byte : 8'h00;
   wire [7:0] clr_input = (wr_first && cmd == CMD_STATUS_INPUT) ? rx_byte : 8'h00;
   wire [7:0] clr_cml = (wr_first && cmd == CMD_STATUS_CML) ? rx_byte : 8'h00;
   wire [7:0] set_vout = {4'h0, ceil_warn_ev, 3'h0};
   wire [7:0] set_input = {2'h0, vin_warn_ev, 5'h00};
   wire [7:0] set_cml = {1'b0, invalid_ev, 6'h00};
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         status_vout <= 8'h00;
         status_input <= 8'h00;
         status_cml <= 8'h00;
      end else begin
         status_vout <= (status_vout & ~clr_vout) | set_vout;
         status_input <= (status_input & ~clr_input) | set_input;
         status_cml <= (status_cml & ~clr_cml) | set_cml;
      end
   end

   // Alert pulls low while any unmasked source is set
   wire alert_src = |(status_vout & ~alert_mask) | |(status_input & ~alert_mask)
      | |(status_cml & ~alert_mask);
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) alert_oe <= 1'b0;
      else alert_oe <= alert_src;
   end
   assign alert_out = 1'b0;

   // Input monitor; turning back on belongs to the start threshold, so no hysteresis here
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         vin_armed <= 1'b0;
         conversion_enable <= 1'b0;
      end else if (vin_sample_valid) begin
         if (vin_above_uv) vin_armed <= 1'b1;
         conversion_enable <= !vin_le_off;
      end
   end

   // Target selection and clamping
   wire [1:0] range_sel = channel_configuration[CC_RANGE_LO +: 2];
   wire [15:0] range_max = (range_sel == 2'h0) ? HF_1V375 :
      (range_sel == 2'h1) ? HF_2V75 : HF_5V5;
   wire [15:0] eff_ceil = pmv_hf_lt(range_max, regs[IDX_CEILING]) ? range_max : regs[IDX_CEILING];
   wire op_nom = operation == OP_NOMINAL;
   wire op_mhi = operation == OP_MARGIN_HIGH;
   wire op_mlo = operation == OP_MARGIN_LOW;
   wire [15:0] sel_target = op_mhi ? regs[IDX_MHIGH] :
      op_mlo ? regs[IDX_MLOW] : regs[IDX_SETPOINT];
   wire [15:0] capped = pmv_hf_lt(eff_ceil, sel_target) ? eff_ceil : sel_target;
   wire [15:0] floored = pmv_hf_lt(capped, HF_0V4) ? HF_0V4 : capped;
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         output_on <= 1'b0;
         target_voltage <= 16'h0000;
      end else begin
         output_on <= op_nom || op_mhi || op_mlo;
         target_voltage <= floored;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_b);

   format_read_a: assert property (
      byte_done && state == ST_ADDR && addr_hit && rx_byte[0] && cmd == CMD_FORMAT
      |=> tx_byte == FORMAT_VALUE) else $error("format byte not 0x60");
   nominal_clamp_a: assert property (
      op_nom && $stable(operation) && $stable(regs[IDX_SETPOINT]) && $stable(regs[IDX_CEILING])
      && !pmv_hf_lt(regs[IDX_SETPOINT], HF_0V4) && !pmv_hf_lt(range_max, regs[IDX_CEILING])
      |=> output_on && target_voltage == (pmv_hf_lt(regs[IDX_CEILING], regs[IDX_SETPOINT])
      ? regs[IDX_CEILING] : regs[IDX_SETPOINT])) else $error("nominal target wrong");
   target_cap_a: assert property (
      output_on |-> !pmv_hf_lt($past(eff_ceil), target_voltage)) else $error("target above ceiling");
   ceil_warn_a: assert property (
      ceil_warn_ev |=> status_vout[SV_MAX_WARN] && status_byte[SB_NONE] && status_word[SW_VOUT])
      else $error("ceiling warning not raised");
   vin_arm_a: assert property (
      !vin_armed && !status_input[SI_VIN_UV] |=> !status_input[SI_VIN_UV])
      else $error("input warning before arming");
   vin_alert_a: assert property (
      vin_warn_ev && !alert_mask[SI_VIN_UV] |=> status_word[SW_INPUT] ##1 alert_oe)
      else $error("input warning did not alert");
   input_turn_off_threshold_a: assert property (
      vin_sample_valid && vin_le_off |=> !conversion_enable) else $error("conversion not stopped");
   ceil_range_a: assert property (
      wr_word_ev && wr_idx == IDX_CEILING && pmv_hf_lt(HF_5V5, wr_data)
      |=> status_cml[SC_INVALID] && $stable(regs[IDX_CEILING])) else $error("bad ceiling kept");
   ovf_order_a: assert property (
      wr_word_ev && wr_idx == IDX_OVF && !pmv_hf_lt(regs[IDX_UVW], wr_data)
      |=> status_cml[SC_INVALID] && status_byte[SB_CML]) else $error("fault order not checked");

   read_cov: cover property (byte_done && state == ST_ADDR && addr_hit && rx_byte[0]);
   store_cov: cover property (word_store);
   warn_cov: cover property (vin_warn_ev);
   margin_cov: cover property (output_on && op_mhi);

endmodule : pmv_voltage_limits
`default_nettype wire

// >>> test/pmv_host.sv
// Partner model: a PMBus host bit-banging clock and data.
// Assumes a pull-up on data; the device pulls low through sda_oe.
`timescale 1ns/1ps
`default_nettype none
module pmv_host
   import pmv_pkg::*;
(
   // System
   input wire logic clk,
   // Bus wire
   input wire logic sda_oe,
   output logic scl = 1'b1,
   output logic sda_in,
   // Read results
   output logic [7:0] rd_data = 8'h00,
   output logic rd_done = 1'b0
);
   logic low = 1'b0;
   // Open drain: either party pulls low, else the pull-up wins
   assign sda_in = !(low || sda_oe);
   task automatic w(input int k);
      repeat (k) @(posedge clk);
   endtask : w
   // Six clocks a phase, safely above the 4-clock minimum
   task automatic st(input logic c, input logic l);
      scl <= c;
      low <= l;
      w(6);
   endtask : st
   // Data moves only with the clock low; ninth bit is the acknowledge
   task automatic xb(input logic [8:0] t, output logic [7:0] r);
      for (int i = 8; i >= 0; i--) begin
         st(1'b0, low);
         st(1'b0, !t[i]);
         st(1'b1, !t[i]);
         if (i > 0) r[i-1] = sda_in;
      end
   endtask : xb
   // Clock drops first, so a held acknowledge is released before a restart
   task automatic hdr(input logic [7:0] c);
      logic [7:0] r;
      st(1'b0, 1'b0); st(1'b1, 1'b0); st(1'b1, 1'b1);
      xb({DEV_ADDR, 1'b0, 1'b1}, r);
      xb({c, 1'b1}, r);
   endtask : hdr
   task automatic stop;
      st(1'b0, low); st(1'b0, 1'b1); st(1'b1, 1'b1); st(1'b1, 1'b0);
   endtask : stop
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input int nb);
      logic [7:0] r;
      hdr(c);
      for (int i = 0; i < nb; i++) xb({d[8*i +: 8], 1'b1}, r);
      stop();
   endtask : wr
   // Acknowledge every byte but the last
   task automatic rd(input logic [7:0] c, input int nb);
      logic [7:0] r;
      hdr(c);
      st(1'b0, 1'b0); st(1'b1, 1'b0); st(1'b1, 1'b1);
      xb({DEV_ADDR, 1'b1, 1'b1}, r);
      for (int i = 0; i < nb; i++) begin
         xb({8'hFF, i == nb - 1}, r);
         rd_data <= r;
         rd_done <= 1'b1;
         w(1);
         rd_done <= 1'b0;
      end
      stop();
   endtask : rd
endmodule : pmv_host
`default_nettype wire

// >>> test/pmv_voltage_limits_tb.sv
// Bench for the voltage limit bank: bus traffic, ADC samples, targets.
// Assumes pmv_host as partner; straps off through global bit 6 until the second power-up.
`timescale 1ns/1ps
`default_nettype none
module pmv_voltage_limits_tb;
   import pmv_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, vld = 1'b0, pop = 1'b0;
   logic scl, sda_in, sda_oe, alert_oe, conv, on, rd_done;
   logic [7:0] gcfg = 8'h40, ccfg = 8'h04, rd_data;
   logic [15:0] target, vin = 16'h0000;
   logic [79:0] rsv = 80'h0;
   logic [31:0] seed = 32'hAB862BDB;
   logic [7:0] exp_q [$];
   logic [7:0] codes [4] = '{CMD_OV_WARN, CMD_POWER_BAD, CMD_INPUT_OFF, CMD_INPUT_LOW};
   int n_fail = 0;
   int tests_run = 0;
   pmv_voltage_limits dut (.clk(clk), .rst_b(rst_b), .scl(scl), .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe),
      .alert_out(), .alert_oe(alert_oe), .vin_sample(vin), .vin_sample_valid(vld), .global_configuration(gcfg),
      .channel_configuration(ccfg), .res_populated(pop), .res_setpoint(rsv[15:0]), .res_ceiling(rsv[31:16]),
      .res_margin_high(rsv[47:32]), .res_margin_low(rsv[63:48]), .res_ov_fault(rsv[79:64]), .conversion_enable(conv),
      .output_on(on), .target_voltage(target));
   pmv_host host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda_in(sda_in), .rd_data(rd_data), .rd_done(rd_done));
   initial forever #2 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("Error at %0t ns: saw %h expected %h", $time, s, e);
      end
   endtask : chk
   // Note expected bytes, low first, then let the host fetch them
   task automatic rdq(input logic [7:0] c, input logic [15:0] e, input int nb);
      exp_q.push_back(e[7:0]);
      if (nb > 1) exp_q.push_back(e[15:8]);
      host.rd(c, nb);
   endtask : rdq
   // One sample pulse; flags land within two edges
   task automatic adc(input logic [15:0] v);
      vin <= v;
      vld <= 1'b1;
      host.w(1);
      vld <= 1'b0;
      host.w(3);
   endtask : adc
   task automatic op(input logic [7:0] o, input logic [15:0] e);
      host.wr(CMD_OPERATION, {8'h00, o}, 1);
      host.w(4);
      chk(target, e);
      chk(on, 1'b1);
   endtask : op
   task automatic test_done;
      if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done
   // Each byte read back is paired with the oldest note
   always @(posedge clk) if (rd_done) chk(rd_data, exp_q.pop_front());
   initial begin
      host.w(90000);
      n_fail++;
      test_done();
   end
   // Main sequence
   initial begin
      host.w(1);
      seed = lfsr(seed);
      rsv <= {seed[15:0], ~seed, seed};
      pop <= seed[16];
      host.w(11);
      rst_b <= 1'b1;
      host.w(8);
      rdq(CMD_FORMAT, 16'h0060, 1);
      rdq(CMD_CEILING, 16'h384C, 2);
      rdq(CMD_SETPOINT, 16'h3800, 2);
      host.wr(CMD_SETPOINT, 16'h3A00, 2);
      rdq(CMD_SETPOINT, 16'h3A00, 2);
      rdq(CMD_STATUS_VOUT, 16'h0008, 1);
      op(OP_NOMINAL, 16'h384C);
      op(OP_MARGIN_HIGH, 16'h3833);
      op(OP_MARGIN_LOW, 16'h379A);
      host.wr(CMD_CEILING, HF_6V0, 2);
      rdq(CMD_CEILING, 16'h384C, 2);
      rdq(CMD_STATUS_CML, 16'h0040, 1);
      host.wr(CMD_CEILING, 16'h4000, 2);
      host.wr(CMD_SETPOINT, 16'h3E00, 2);
      ccfg <= 8'h00;
      op(OP_NOMINAL, HF_1V375);
      ccfg <= 8'h02;
      op(OP_NOMINAL, 16'h3E00);
      host.wr(CMD_OV_FAULT, 16'h3700, 2);
      rdq(CMD_OV_FAULT, 16'h3866, 2);
      foreach (codes[i]) begin
         host.wr(codes[i], 16'h4000, 2);
         rdq(codes[i], 16'h4000, 2);
      end
      // Mask the ceiling and invalid-data bits so only the input warning can alert
      host.wr(CMD_ALERT_MASK, 16'h0048, 1);
      adc(16'h3C00);
      chk(conv, 1'b0);
      chk(alert_oe, 1'b0);
      seed = lfsr(seed);
      adc({6'h11, seed[9:0]});
      chk(conv, 1'b1);
      adc(16'h3C00);
      chk(alert_oe, 1'b1);
      chk(conv, 1'b0);
      rdq(CMD_STATUS_INPUT, 16'h0020, 1);
      rdq(CMD_STATUS_BYTE, 16'h0003, 1);
      // Second power-up with straps live; sticky status must be gone
      gcfg <= 8'h00;
      pop <= 1'b1;
      rst_b <= 1'b0;
      host.w(12);
      rst_b <= 1'b1;
      host.w(8);
      chk(alert_oe, 1'b0);
      rdq(CMD_SETPOINT, rsv[15:0], 2);
      rdq(CMD_OV_FAULT, rsv[79:64], 2);
      test_done();
   end
endmodule : pmv_voltage_limits_tb
`default_nettype wire
